/* File: rtl/wdr_top.sv */
// Watchdog timer with power-fail reset and memory write inhibit.
// Notes on behaviour
// RULE1: Host software writes the kick port at least once every 1.5 s.
// RULE2: With no kick before 1.5 s elapse, reset is driven low for 50 ms.
// RULE3: Every kick restarts the full timeout from zero.
// RULE4: The disable jumper stops a watchdog expiry from making a reset.
// RULE5: While supply is out of tolerance, the system reset is held low.
// RULE6: While supply is out of tolerance, memory write strobe stays off.
// RULE7: Any decoded kick write counts regardless of data; reset clears count.
`timescale 1ns/1ps

module wdr_top
    import wdr_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int PULSE_CYCLES   = PULSE_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    // Processor I/O write cycle, same clock domain
    input  wire wdr_io_t    io_in,
    // Processor memory write strobe, active low, from the processor
    input  wire logic       mem_wr_n_in,
    // Board pins: supply fault and watchdog disable jumper
    input  wire logic       supply_fault_in,
    input  wire logic       wdog_disable_in,
    // Outputs
    output logic            system_reset_n_out,
    output logic            mem_wr_n_out,
    output logic            wdog_expired_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Both pins come up as fault and disabled, so reset is driven low for the
    // first cycles after release until the synchronisers have settled.
    logic fault_sync;
    logic dis_sync;

    wdr_sync #(.RST_VAL(1'b1)) u_sync_fault (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .d_in       (supply_fault_in),
        .q_out      (fault_sync)
    );

    wdr_sync #(.RST_VAL(1'b1)) u_sync_dis (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .d_in       (wdog_disable_in),
        .q_out      (dis_sync)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wdr_state_t      state_reg;
    wdr_state_t      state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic            reset_reg;
    logic            kick;
    logic            timeout_hit;
    logic            pulse_done;

    // Any write to the kick address retriggers; data is not looked at.
    assign kick        = io_in.wr && (io_in.addr == KICK_PORT_ADDR); // RULE7
    assign timeout_hit = (cnt_reg == CNT_W'(TIMEOUT_CYCLES - 1));
    assign pulse_done  = (cnt_reg == CNT_W'(PULSE_CYCLES - 1));

    // Next state: count, fire a pulse, or hold off while supply is bad.
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + CNT_W'(1);
        case (state_reg)
            WDR_ST_COUNT: begin
                if (fault_sync) begin
                    state_next = WDR_ST_HOLD;
                    cnt_next   = '0;
                end else if (kick) begin
                    cnt_next = '0; // RULE3
                end else if (timeout_hit) begin
                    cnt_next   = '0;
                    state_next = dis_sync ? WDR_ST_COUNT : WDR_ST_FIRE; // RULE4
                end
            end
            WDR_ST_FIRE: begin
                if (pulse_done) begin // RULE2
                    state_next = WDR_ST_COUNT;
                    cnt_next   = '0;
                end
            end
            WDR_ST_HOLD: begin
                cnt_next = '0;
                if (!fault_sync) begin
                    state_next = WDR_ST_COUNT;
                end
            end
            default: begin
                state_next = WDR_ST_COUNT;
                cnt_next   = '0;
            end
        endcase
    end

    // State and counter registers; reset clears the count.
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            state_reg <= WDR_ST_COUNT;
            cnt_reg   <= '0; // RULE7
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Registered reset output: low while firing or supply is bad.
    // It looks at the next state, so the pin falls on the same edge at
    // which the state enters firing and rises on the edge that leaves it.
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            reset_reg <= RESET_IDLE;
        end else begin
            reset_reg <= !((state_next == WDR_ST_FIRE) || fault_sync); // RULE5
        end
    end

    // Reset pin comes from a flop; the expiry flag is decoded from state.
    assign system_reset_n_out = reset_reg;
    assign wdog_expired_out   = (state_reg == WDR_ST_FIRE);
    // Write strobe forced inactive during a supply fault.
    assign mem_wr_n_out = mem_wr_n_in | fault_sync; // RULE6

    // ------------------------------------------------------------------
    // Pulse length monitor
    // ------------------------------------------------------------------
    // Counts firing cycles apart from the timeout counter, so that a pulse
    // that starts from a stale count is caught by the checks below.
    logic [CNT_W-1:0] fire_len_reg;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in || state_reg != WDR_ST_FIRE) begin
            fire_len_reg <= '0;
        end else begin
            fire_len_reg <= fire_len_reg + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    a_fault_resets: assert property ( // RULE5
        fault_sync |=> !system_reset_n_out)
        else $error("Reset not low during supply fault.");

    a_fault_no_write: assert property ( // RULE6
        fault_sync |-> mem_wr_n_out)
        else $error("Write strobe passed during supply fault.");

    a_kick_clears: assert property ( // RULE3
        (state_reg == WDR_ST_COUNT && kick && !fault_sync) |=> cnt_reg == 0)
        else $error("Kick did not restart the timeout.");

    a_expiry_fires: assert property ( // RULE2
        (state_reg == WDR_ST_COUNT && timeout_hit && !kick && !fault_sync
         && !dis_sync) |=> (state_reg == WDR_ST_FIRE) ##0 !system_reset_n_out)
        else $error("Expiry did not start a reset pulse.");

    a_pulse_length: assert property ( // RULE2
        (state_reg == WDR_ST_FIRE && pulse_done && !fault_sync)
        |=> state_reg == WDR_ST_COUNT ##1 system_reset_n_out || fault_sync)
        else $error("Reset pulse length wrong.");

    a_disable_blocks: assert property ( // RULE4
        (state_reg == WDR_ST_COUNT && dis_sync && !fault_sync)
        |=> state_reg != WDR_ST_FIRE)
        else $error("Disabled watchdog fired.");

    a_no_early_fire: assert property ( // RULE3
        (state_reg == WDR_ST_COUNT && !timeout_hit)
        |=> state_reg != WDR_ST_FIRE)
        else $error("Watchdog fired before timeout.");

    a_idle_high: assert property ( // RULE5
        (state_reg == WDR_ST_COUNT && !fault_sync && $past(!fault_sync)
         && $past(state_reg == WDR_ST_COUNT)) |-> system_reset_n_out)
        else $error("Reset low without cause.");

    // Outputs and counter around pulses, other ports and reset.
    a_wr_passes: assert property ( // RULE6
        !fault_sync |-> mem_wr_n_out == mem_wr_n_in)
        else $error("Write strobe blocked without supply fault.");

    a_expired_low: assert property ( // RULE2
        wdog_expired_out |-> !system_reset_n_out)
        else $error("Expiry flag high while reset released.");

    a_pulse_exact: assert property ( // RULE2
        (state_reg == WDR_ST_FIRE && state_next != WDR_ST_FIRE)
        |-> fire_len_reg == CNT_W'(PULSE_CYCLES - 1))
        else $error("Reset pulse ended at the wrong cycle.");

    a_pulse_bound: assert property ( // RULE2
        (state_reg == WDR_ST_FIRE) |-> fire_len_reg < CNT_W'(PULSE_CYCLES))
        else $error("Reset pulse ran past its length.");

    a_other_port: assert property ( // RULE7
        (state_reg == WDR_ST_COUNT && io_in.wr && !kick && !timeout_hit
         && !fault_sync) |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
        else $error("Write to another port touched the timeout.");

    a_reset_clears: assert property ( // RULE7
        disable iff (1'b0) !rstn_in |=> cnt_reg == '0)
        else $error("Timeout count not cleared by reset.");

    c_kick: cover property (kick);
    c_fire: cover property (state_reg == WDR_ST_FIRE);
    c_fault: cover property (fault_sync ##1 !fault_sync);
    c_dis_expiry: cover property (state_reg == WDR_ST_COUNT && timeout_hit
        && dis_sync);
    c_pulse_end: cover property (state_reg == WDR_ST_FIRE && pulse_done);

endmodule : wdr_top

/* File: rtl/wdr_pkg.sv */
// Package holding constants and types of the watchdog and power-fail reset.
package wdr_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ        = 25000000;
    localparam longint TIMEOUT_MS    = 1500;
    localparam longint PULSE_MS      = 50;
    localparam int     TIMEOUT_CYC   = int'((TIMEOUT_MS * CLK_HZ) / 1000);
    localparam int     PULSE_CYC     = int'((PULSE_MS * CLK_HZ + 999) / 1000);
    localparam int     CNT_W         = 32;

    // ------------------------------------------------------------------
    // Decoding and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] KICK_PORT_ADDR = 8'h8f;
    localparam logic       RESET_IDLE     = 1'b1;

    // Watchdog states, Gray along counting, firing, holding.
    typedef enum logic [1:0] {
        WDR_ST_COUNT = 2'b00,
        WDR_ST_FIRE  = 2'b01,
        WDR_ST_HOLD  = 2'b11
    } wdr_state_t;

    // Processor I/O write cycle as seen by the block.
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
    } wdr_io_t;

endpackage : wdr_pkg

/* File: rtl/wdr_sync.sv */
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps

module wdr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    // Level
    input  wire logic d_in,
    output logic      q_out
);

    logic meta_reg;

    // The first flop feeds only the second one.
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            meta_reg <= RST_VAL;
            q_out    <= RST_VAL;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end

endmodule : wdr_sync

/* File: bench/wdr_host.sv */
// Host model that writes the kick port and neighbouring I/O ports.
`timescale 1ns/1ps

module wdr_host
    import wdr_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    // Control from the bench
    input  wire logic       kick_en_in,
    input  wire logic [7:0] period_in,
    // I/O write cycles
    output wdr_io_t         io_out
);
    int         cnt_reg = 0;
    logic       kick;
    logic       noise;
    logic [7:0] addr;

    initial io_out = '0;

    // Kicks at count zero, odd counts write other ports as noise.
    // Controls are read at the edge, the cycle is driven just after it.
    always @(posedge ref_clk_in) begin
        kick  = kick_en_in && cnt_reg == 0;
        noise = cnt_reg[0];
        addr  = kick ? KICK_PORT_ADDR : 8'h80 + 8'(cnt_reg % 15);
        if (!rstn_in || cnt_reg + 1 >= int'(period_in))
            cnt_reg = 0;
        else
            cnt_reg = cnt_reg + 1;
        #1;
        io_out.wr   <= kick || noise;
        io_out.addr <= addr;
    end
endmodule : wdr_host

/* File: bench/wdr_top_tb.sv */
// Self-checking bench for the watchdog and power-fail reset.
`timescale 1ns/1ps

module wdr_top_tb;
    import wdr_pkg::*;
    localparam int TO = 100;
    localparam int PW = 10;
    logic    ref_clk_in = 1'b0;
    logic    rstn_in    = 1'b0;
    logic    kick_en    = 1'b0;
    logic    mem_wr_n   = 1'b1;
    logic    fault      = 1'b0;
    logic    wdog_dis   = 1'b0;
    logic    watch      = 1'b0;
    wdr_io_t io;
    logic    rst_n;
    logic    mem_wr_q;
    logic    expired;
    int      miscompares = 0;
    int      num_checks  = 0;
    int      seed = 28155;
    int      len = 0;
    int      xl = 0;
    int      cyc = 0;
    int      exp_q[$];

    // Clock at 25 MHz.
    always #20 ref_clk_in = ~ref_clk_in;

    wdr_top #(.TIMEOUT_CYCLES(TO), .PULSE_CYCLES(PW)) u_wdr_top (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .io_in(io),
        .mem_wr_n_in(mem_wr_n), .supply_fault_in(fault),
        .wdog_disable_in(wdog_dis), .system_reset_n_out(rst_n),
        .mem_wr_n_out(mem_wr_q), .wdog_expired_out(expired));

    wdr_host u_wdr_host (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .kick_en_in(kick_en), .period_in(8'h28), .io_out(io));

    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (e !== s) begin
            miscompares++;
            $display("MISMATCH %s exp %0h got %0h", n, e, s);
        end
    endtask : chk

    task automatic step(int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : step

    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // Measures each reset pulse and compares it with the oldest notes.
    always @(negedge ref_clk_in) begin
        if (watch && rst_n !== 1'b0 && expired !== 1'b0)
            chk("expired_idle", 0, expired);
        if (watch && rst_n === 1'b0) begin
            len++;
            xl += int'(expired === 1'b1);
        end else if (watch && len > 0) begin
            chk("pulse_len", exp_q.size() ? exp_q.pop_front() : 0, len);
            chk("expired_len", exp_q.size() ? exp_q.pop_front() : 0, xl);
            len = 0;
            xl = 0;
        end
    end

    // Cuts a hung run short.
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // Main sequence of scenarios.
    initial begin
        step(5);
        rstn_in = 1'b1;
        kick_en = 1'b1;
        step(20);
        watch = 1'b1;
        step(300);
        kick_en = 1'b0;
        exp_q.push_back(PW);
        exp_q.push_back(PW);
        step(115);
        kick_en = 1'b1;
        wdog_dis = 1'b1;
        step(3);
        kick_en = 1'b0;
        step(250);
        kick_en = 1'b1;
        step(45);
        wdog_dis = 1'b0;
        exp_q.push_back(20);
        exp_q.push_back(0);
        fault = 1'b1;
        for (int i = 0; i < 20; i++) begin
            mem_wr_n = 1'($random(seed));
            @(negedge ref_clk_in);
            if (i > 2) chk("mem_wr_gate", 1, mem_wr_q);
            step(1);
        end
        fault = 1'b0;
        step(3);
        for (int i = 0; i < 8; i++) begin
            mem_wr_n = 1'($random(seed));
            @(negedge ref_clk_in);
            chk("mem_wr_pass", mem_wr_n, mem_wr_q);
            step(1);
        end
        step(40);
        chk("notes_left", 0, exp_q.size());
        report_and_stop();
    end
endmodule : wdr_top_tb
